// ### status_code_display_sequencer.sv
`timescale 1ns/1ps
`include "status_display_consts.svh"
module status_code_display_sequencer #(
  parameter int REFRESH_CYCLES = `REFRESH_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      upd_valid,
  input  wire logic [5:0]                upd_node,
  input  wire status_display_pkg::code_t upd_code,
  input  wire logic [5:0]                own_node,
  input  wire logic                      startup_done,
  input  wire logic                      lamp_test,
  input  wire logic                      scan_overrun,
  input  wire logic [4:0]                class_active,
  input  wire status_display_pkg::code_t scanner_err_code,
  input  wire status_display_pkg::code_t can_hw_code,
  input  wire status_display_pkg::code_t net_access_code,
  input  wire status_display_pkg::code_t app_thread_code,
  input  wire status_display_pkg::code_t monitor_code,
  output status_display_pkg::code_t      upper_val_reg,
  output status_display_pkg::code_t      lower_val_reg,
  output status_display_pkg::seg_t       upper_tens_seg_reg,
  output status_display_pkg::seg_t       upper_ones_seg_reg,
  output status_display_pkg::seg_t       lower_tens_seg_reg,
  output status_display_pkg::seg_t       lower_ones_seg_reg,
  output logic                           unlisted_code_reg,
  output logic                           refresh_reg
);
  import status_display_pkg::*;

  localparam logic [6:0] LAST_IDX = 7'(`NODE_COUNT + `CLASS_COUNT - 1);

  // Segments active high, bit order g f e d c b a
  function automatic seg_t seg_of(input logic [3:0] d);
    case (d)
      4'h0: seg_of = 7'h3F;
      4'h1: seg_of = 7'h06;
      4'h2: seg_of = 7'h5B;
      4'h3: seg_of = 7'h4F;
      4'h4: seg_of = 7'h66;
      4'h5: seg_of = 7'h6D;
      4'h6: seg_of = 7'h7D;
      4'h7: seg_of = 7'h07;
      4'h8: seg_of = 7'h7F;
      4'h9: seg_of = 7'h6F;
      default: seg_of = 7'h40;
    endcase
  endfunction

  function automatic logic [3:0] tens(input code_t v);
    tens = 4'(v / 7'd10);
  endfunction

  function automatic logic [3:0] ones(input code_t v);
    ones = 4'(v % 7'd10);
  endfunction

  function automatic logic listed(input code_t c);
    listed = (c >= `BASIC_LO && c <= `BASIC_HI)
          || (c >= `TIMEOUT_CODE && c <= `CONN_NEEDED)
          || (c >= `UCMM_TRY1 && c <= `MS_TRY_FAIL)
          || (c > `MS_TRY_FAIL && c < `ID_WAIT_LO)
          || (c >= `ID_WAIT_LO && c <= `ID_WAIT_HI)
          || (c > `ID_WAIT_HI && c <= `CODE_NODE_NORMAL)
          || (c >= `DISC_MS_LO && c <= `DISC_UCMM_HI)
          || (c == `OTHER_ERR)
          || (c == `STATE_FAULT)
          || (c >= `ID_BAD_LO && c <= `ID_BAD_HI)
          || (c > `ID_BAD_HI && c < `EPR_STROBE)
          || (c >= `EPR_STROBE && c <= `EPR_COS)
          || (c > `EPR_COS && c <= `MISC_ERR_HI)
          || (c >= `CODE_SCANNER_OK && c <= `SCAN_RUN)
          || (c >= `SCAN_SCANNING && c <= `SCAN_STATE_HI);
  endfunction

  logic [31:0]  tick_cnt_reg;
  logic         tick;
  seq_state_e   state_reg;
  logic [6:0]   idx_reg;
  logic [6:0]   steps_reg;
  logic [63:0]  in_list_reg;
  code_t        rd_data;
  code_t        class_num [`CLASS_COUNT];
  code_t        class_code [`CLASS_COUNT];
  logic         entry_active;
  code_t        entry_code;
  logic         load;
  code_t        upper_next;
  code_t        lower_next;
  logic         unlisted_next;

  node_code_ram #(.DEPTH(`NODE_COUNT), .AW(6)) u_codes (
    .core_clk (core_clk),
    .wr_en    (upd_valid),
    .wr_addr  (upd_node),
    .wr_data  (upd_code),
    .rd_addr  (idx_reg[5:0]),
    .rd_data  (rd_data)
  );

  // Timebase restarts at each load, so a long search never shortens the next gap
  assign tick = (tick_cnt_reg == 32'(REFRESH_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= '0;
    else if (load)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'd1;
  end

  // Code 0 written for a node takes it off the list
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      in_list_reg <= '0;
    else if (upd_valid)
      in_list_reg[upd_node] <= (upd_code != `CODE_NONE);
  end

  assign class_num[0] = `CLASS_SCANNER;
  assign class_num[1] = `CLASS_CAN_HW;
  assign class_num[2] = `CLASS_NET_ACCESS;
  assign class_num[3] = `CLASS_APP_THREAD;
  assign class_num[4] = `CLASS_MONITOR;
  assign class_code[0] = scan_overrun ? `CODE_SCAN_OVERRUN : scanner_err_code;
  assign class_code[1] = can_hw_code;
  assign class_code[2] = net_access_code;
  assign class_code[3] = app_thread_code;
  assign class_code[4] = monitor_code;

  always_comb
  begin
    logic [2:0] k;
    k = 3'(idx_reg - 7'(`NODE_COUNT));
    if (idx_reg <= `NODE_MAX)
    begin
      // A listed node is skipped only once startup is over and it runs normally
      entry_active = in_list_reg[idx_reg[5:0]]
                  && (!startup_done || rd_data != `CODE_NODE_NORMAL);
      entry_code = rd_data;
    end
    else
    begin
      entry_active = class_active[k] || (k == 3'd0 && scan_overrun);
      entry_code = class_code[k];
    end
  end

  // Search takes two cycles per entry, far below the refresh period
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_WAIT;
      idx_reg <= LAST_IDX;
      steps_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_WAIT:
        begin
          steps_reg <= '0;
          if (tick && !lamp_test)
          begin
            state_reg <= ST_READ;
            idx_reg <= (idx_reg >= LAST_IDX) ? 7'h00 : idx_reg + 7'd1;
          end
        end
        ST_READ:
          state_reg <= ST_CHECK;
        ST_CHECK:
        begin
          if (entry_active || steps_reg == LAST_IDX)
            state_reg <= ST_WAIT;
          else
          begin
            state_reg <= ST_READ;
            steps_reg <= steps_reg + 7'd1;
            idx_reg <= (idx_reg >= LAST_IDX) ? 7'h00 : idx_reg + 7'd1;
          end
        end
        default:
          state_reg <= ST_WAIT;
      endcase
    end
  end

  always_comb
  begin
    load = 1'b0;
    upper_next = upper_val_reg;
    lower_next = lower_val_reg;
    unlisted_next = 1'b0;
    if (state_reg == ST_WAIT && tick && lamp_test)
    begin
      load = 1'b1;
      upper_next = `CLASS_LAMP_TEST;
      lower_next = `CODE_LAMP_TEST;
    end
    else if (state_reg == ST_CHECK && entry_active)
    begin
      load = 1'b1;
      upper_next = (idx_reg <= `NODE_MAX) ? idx_reg : class_num[3'(idx_reg - 7'(`NODE_COUNT))];
      lower_next = entry_code;
      if (idx_reg <= `NODE_MAX)
      begin
        unlisted_next = !listed(entry_code);
        if (entry_code == `CODE_NODE_NORMAL)
          lower_next = `CODE_NODE_SHOWN;
      end
    end
    else if (state_reg == ST_CHECK && steps_reg == LAST_IDX)
    begin
      // Nothing to report: quiet display of the scanner itself
      load = 1'b1;
      upper_next = 7'(own_node);
      lower_next = startup_done ? `CODE_SCANNER_OK : `SCAN_STATE_LO;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upper_val_reg <= '0;
      lower_val_reg <= '0;
      upper_tens_seg_reg <= 7'h3F;
      upper_ones_seg_reg <= 7'h3F;
      lower_tens_seg_reg <= 7'h3F;
      lower_ones_seg_reg <= 7'h3F;
      unlisted_code_reg <= 1'b0;
      refresh_reg <= 1'b0;
    end
    else
    begin
      refresh_reg <= load;
      if (load)
      begin
        upper_val_reg <= upper_next;
        lower_val_reg <= lower_next;
        upper_tens_seg_reg <= seg_of(tens(upper_next));
        upper_ones_seg_reg <= seg_of(ones(upper_next));
        lower_tens_seg_reg <= seg_of(tens(lower_next));
        lower_ones_seg_reg <= seg_of(ones(lower_next));
        unlisted_code_reg <= unlisted_next;
      end
    end
  end

  // Helper: cycles since the last display load
  logic [31:0] since_load_reg;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      since_load_reg <= 32'hFFFF_FFFF;
    else if (refresh_reg)
      since_load_reg <= '0;
    else if (since_load_reg != 32'hFFFF_FFFF)
      since_load_reg <= since_load_reg + 32'd1;
  end

  a_refresh_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    refresh_reg |-> $past(since_load_reg) >= 32'(REFRESH_CYCLES - 2))
    else $error("display refreshed too soon");

  a_upper_class: assert property (@(posedge core_clk) disable iff (!rst_n)
    upper_val_reg > `NODE_MAX |-> upper_val_reg inside {`CLASS_LAMP_TEST, `CLASS_SCANNER,
      `CLASS_CAN_HW, `CLASS_NET_ACCESS, `CLASS_APP_THREAD, `CLASS_MONITOR})
    else $error("upper field above 63 is no class");

  a_lamp_show: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_WAIT && tick && lamp_test |=> refresh_reg && upper_val_reg == `CLASS_LAMP_TEST
      && lower_ones_seg_reg == 7'h7F)
    else $error("lamp test not shown");

  a_idle_ok: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_CHECK && !entry_active && steps_reg == LAST_IDX && startup_done
      |=> upper_val_reg == 7'($past(own_node)) && lower_val_reg == `CODE_SCANNER_OK)
    else $error("clean state not shown as own node and 80");

  a_normal_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_CHECK && entry_active && idx_reg <= `NODE_MAX && rd_data == `CODE_NODE_NORMAL
      |=> lower_val_reg == `CODE_NODE_SHOWN && lower_tens_seg_reg == 7'h3F)
    else $error("normal node not shown as 00");

  a_overrun_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_CHECK && idx_reg == 7'(`NODE_COUNT) && scan_overrun
      |=> upper_val_reg == `CLASS_SCANNER && lower_val_reg == `CODE_SCAN_OVERRUN)
    else $error("scan overrun not shown");

  a_seg_match: assert property (@(posedge core_clk) disable iff (!rst_n)
    refresh_reg |-> upper_tens_seg_reg == seg_of(tens(upper_val_reg))
      && lower_ones_seg_reg == seg_of(ones(lower_val_reg)))
    else $error("segments disagree with field value");

  a_search_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_READ |-> ##[1:140] state_reg == ST_WAIT)
    else $error("search did not finish");

  a_field_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_CHECK && entry_active && idx_reg <= `NODE_MAX && rd_data != `CODE_NODE_NORMAL
      |=> upper_val_reg == $past(idx_reg) && lower_val_reg == $past(rd_data))
    else $error("node and code not paired");
endmodule

// ### status_display_consts.svh
`ifndef STATUS_DISPLAY_CONSTS_SVH
`define STATUS_DISPLAY_CONSTS_SVH

// Timing
`define CLK_PERIOD_NS     50
`define REFRESH_PERIOD_NS 1000000000
`define REFRESH_CYCLES    (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)

// Upper field ranges and category codes
`define NODE_COUNT        64
`define NODE_MAX          7'h3F
`define CLASS_COUNT       5
`define CLASS_LAMP_TEST   7'h58
`define CLASS_SCANNER     7'h5B
`define CLASS_CAN_HW      7'h60
`define CLASS_NET_ACCESS  7'h61
`define CLASS_APP_THREAD  7'h62
`define CLASS_MONITOR     7'h63

// Lower field codes
`define CODE_NONE         7'h00
`define CODE_SCAN_OVERRUN 7'h01
`define CODE_NODE_NORMAL  7'h28
`define CODE_NODE_SHOWN   7'h00
`define CODE_SCANNER_OK   7'h50
`define CODE_LAMP_TEST    7'h58

// Listed node code ranges, inclusive
`define BASIC_LO          7'h01
`define BASIC_HI          7'h03
`define TIMEOUT_CODE      7'h05
`define CONN_NEEDED       7'h07
`define UCMM_TRY1         7'h08
`define MS_TRY_FAIL       7'h0C
`define ID_WAIT_LO        7'h11
`define ID_WAIT_HI        7'h1A
`define DISC_MS_LO        7'h2C
`define DISC_UCMM_HI      7'h31
`define OTHER_ERR         7'h32
`define STATE_FAULT       7'h34
`define ID_BAD_LO         7'h35
`define ID_BAD_HI         7'h3E
`define EPR_STROBE        7'h40
`define EPR_COS           7'h46
`define MISC_ERR_HI       7'h4C
`define SCAN_STATE_LO     7'h51
`define SCAN_RUN          7'h56
`define SCAN_SCANNING     7'h58
`define SCAN_STATE_HI     7'h5E

`endif

// ### status_display_pkg.sv
package status_display_pkg;
  typedef logic [6:0] code_t;
  typedef logic [6:0] seg_t;
  typedef enum logic [1:0] {ST_WAIT, ST_READ, ST_CHECK} seq_state_e;
endpackage

// ### node_code_ram.sv
`timescale 1ns/1ps
module node_code_ram #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic                      core_clk,
  input  wire logic                      wr_en,
  input  wire logic [AW-1:0]             wr_addr,
  input  wire status_display_pkg::code_t wr_data,
  input  wire logic [AW-1:0]             rd_addr,
  output status_display_pkg::code_t      rd_data
);
  import status_display_pkg::*;

  code_t mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### display_reader.sv
`timescale 1ns/1ps
module display_reader (
  input  wire status_display_pkg::seg_t upper_tens_seg,
  input  wire status_display_pkg::seg_t upper_ones_seg,
  input  wire status_display_pkg::seg_t lower_tens_seg,
  input  wire status_display_pkg::seg_t lower_ones_seg,
  output logic [11:0]                   upper_num,
  output logic [11:0]                   lower_num
);
  import status_display_pkg::*;
  localparam seg_t DIGITS [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};

  // An unreadable pattern reads as 200 so the pair can never pass for a valid value
  function automatic logic [11:0] read_digit(seg_t s);
    logic [11:0] d;
    d = 12'hC8;
    for (int i = 0; i < 10; i++)
    begin
      if (s === DIGITS[i])
        d = 12'(i);
    end
    return d;
  endfunction

  // The operator reads both digits of each field, leading zero included
  assign upper_num = read_digit(upper_tens_seg) * 12'h00A + read_digit(upper_ones_seg);
  assign lower_num = read_digit(lower_tens_seg) * 12'h00A + read_digit(lower_ones_seg);
endmodule

// ### status_code_display_sequencer_test.sv
`timescale 1ns/1ps
module status_code_display_sequencer_test;
  import status_display_pkg::*;
  localparam int         RC = 200;
  localparam logic [6:0] CLS [5] = '{7'h5B, 7'h60, 7'h61, 7'h62, 7'h63};
  localparam logic [6:0] TBL [23] = '{7'h01, 7'h02, 7'h03, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B,
                                      7'h0C, 7'h11, 7'h1A, 7'h2C, 7'h31, 7'h35, 7'h3E, 7'h40, 7'h43, 7'h46,
                                      7'h51, 7'h5E, 7'h28};
  logic        core_clk     = 1'b0;
  logic        rst_n        = 1'b0;
  logic        upd_valid    = 1'b0;
  logic [5:0]  upd_node     = 6'h00;
  code_t       upd_code     = 7'h00;
  logic [5:0]  own_node     = 6'h2A;
  logic        startup_done = 1'b0;
  logic        lamp_test    = 1'b0;
  logic        scan_overrun = 1'b0;
  logic [4:0]  class_active = 5'h00;
  code_t       cls_code [5] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  code_t       node_model [64];
  code_t       upper_val_reg;
  code_t       lower_val_reg;
  seg_t        ut_seg;
  seg_t        uo_seg;
  seg_t        lt_seg;
  seg_t        lo_seg;
  logic        unlisted_code_reg;
  logic        refresh_reg;
  logic [11:0] upper_num;
  logic [11:0] lower_num;
  int          errors  = 0;
  int          n_tests = 0;
  int          last    = 68;
  time         t_ref   = 0;

  always #25 core_clk = ~core_clk;

  status_code_display_sequencer #(.REFRESH_CYCLES(RC)) i_status_code_display_sequencer (
    .core_clk(core_clk), .rst_n(rst_n), .upd_valid(upd_valid), .upd_node(upd_node), .upd_code(upd_code),
    .own_node(own_node), .startup_done(startup_done), .lamp_test(lamp_test), .scan_overrun(scan_overrun),
    .class_active(class_active), .scanner_err_code(cls_code[0]), .can_hw_code(cls_code[1]),
    .net_access_code(cls_code[2]), .app_thread_code(cls_code[3]), .monitor_code(cls_code[4]),
    .upper_val_reg(upper_val_reg), .lower_val_reg(lower_val_reg), .upper_tens_seg_reg(ut_seg),
    .upper_ones_seg_reg(uo_seg), .lower_tens_seg_reg(lt_seg), .lower_ones_seg_reg(lo_seg),
    .unlisted_code_reg(unlisted_code_reg), .refresh_reg(refresh_reg));

  display_reader i_display_reader (
    .upper_tens_seg(ut_seg), .upper_ones_seg(uo_seg), .lower_tens_seg(lt_seg), .lower_ones_seg(lo_seg),
    .upper_num(upper_num), .lower_num(lower_num));

  task automatic finish_test();
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask

  // First entry after the last one shown that has a current condition, or -1
  function automatic int exp_next();
    int i;
    for (int k = 1; k <= 69; k++)
    begin
      i = (last + k) % 69;
      if (i < 64 && node_model[i] != 7'h00 && (!startup_done || node_model[i] != 7'h28))
        return i;
      if (i >= 64 && (class_active[i-64] || (i == 64 && scan_overrun)))
        return i;
    end
    return -1;
  endfunction

  // Node codes that no node table lists
  function automatic logic unlisted(input code_t c);
    return !(c inside {[7'h01:7'h03], [7'h05:7'h28], [7'h2C:7'h32], [7'h34:7'h4C], [7'h50:7'h56],
                       [7'h58:7'h5E]});
  endfunction

  task automatic wr(input int n, input code_t c);
    @(posedge core_clk);
    upd_valid <= 1'b1;
    upd_node  <= 6'(n);
    upd_code  <= c;
    node_model[n] = c;
  endtask

  task automatic idle();
    @(posedge core_clk);
    upd_valid <= 1'b0;
  endtask

  task automatic step();
    int         c;
    int         e;
    logic [6:0] eu;
    logic [6:0] el;
    logic       ex;
    c = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      c++;
    end
    while (refresh_reg !== 1'b1 && c < 500);
    if (c >= 500)
    begin
      errors++;
      $display("mismatch at %0t: no refresh", $time);
      finish_test();
    end
    else
    begin
      // Gap since the previous refresh, both seen 1 ns after their edge
      check(12'(($time - t_ref) >= 64'(RC) * 64'd50), 12'h001);
      t_ref = $time;
      e = exp_next();
      ex = 1'b0;
      if (lamp_test)
      begin
        eu = 7'h58;
        el = 7'h58;
      end
      else if (e < 0)
      begin
        eu = 7'(own_node);
        el = startup_done ? 7'h50 : 7'h51;
      end
      else if (e < 64)
      begin
        eu = 7'(e);
        el = (node_model[e] == 7'h28) ? 7'h00 : node_model[e];
        ex = unlisted(node_model[e]);
      end
      else
      begin
        eu = CLS[e-64];
        el = (e == 64 && scan_overrun) ? 7'h01 : cls_code[e-64];
      end
      if (!lamp_test && e >= 0)
        last = e;
      check(12'(upper_val_reg), 12'(eu));
      check(12'(lower_val_reg), 12'(el));
      check(upper_num, 12'(eu));
      check(lower_num, 12'(el));
      check(12'(unlisted_code_reg), 12'(ex));
      // Hand back on a rising edge so the caller's next drive lands there
      @(posedge core_clk);
    end
  endtask

  initial
  begin
    for (int i = 0; i < 64; i++)
      node_model[i] = 7'h00;
    void'($urandom(13));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    step();
    startup_done <= 1'b1;
    step();
    wr(5, 7'h28);
    idle();
    step();
    startup_done <= 1'b0;
    step();
    startup_done <= 1'b1;
    wr(5, 7'h00);
    wr(0, TBL[$urandom_range(21)]);
    wr(63, TBL[$urandom_range(22)]);
    repeat (3) wr($urandom_range(62, 1), TBL[$urandom_range(22)]);
    wr(62, 7'h33);
    idle();
    scan_overrun <= 1'b1;
    class_active <= 5'($urandom_range(31, 16));
    for (int i = 0; i < 5; i++)
      cls_code[i] <= 7'($urandom_range(18, 1));
    repeat (14) step();
    lamp_test <= 1'b1;
    step();
    lamp_test <= 1'b0;
    step();
    scan_overrun <= 1'b0;
    class_active <= 5'h00;
    for (int i = 0; i < 64; i++)
    begin
      if (node_model[i] != 7'h00)
        wr(i, 7'h00);
    end
    idle();
    step();
    finish_test();
  end
endmodule
